// *** timer_compare_pwm_channels.sv ***
// Two-channel output compare and PWM timer with an APB register slave.
// Assumes APB masters hold a request steady through its access phase and
// that the external timer clock input is already synchronous to pclk.
//
// The register offsets and register access over APB were left to the implementer.
`timescale 1ns/1ps

////////////////////////////////////////////////////////////////////////////////
// Operation
// - Unbuffered compare uses the stored channel value directly, replaced at once.
// - Compare fires only when the counter reaches the stored value.
// - Unsynchronized value rewrites may upset output for up to two periods.
// - A larger value written after the compare compares again this period.
// - Channel 0 link select pairs both channels; channel 0 values lead.
// - Linked: last written value set takes over at each wrap.
// - Linked: channel 0 register controls; channel 1 register idle, pin released.
// - The linked pair's output appears on the channel 0 pin.
// - Toggle-on-wrap flips the pin when the counter passes the limit.
// - The period is the limit plus one counter clock.
// - The pulse width is the channel value in counter clocks after wrap.
// - Mode pair 0:1 is unbuffered, 1:0 buffered; high bit wins.
// - Edge/level 1:0 clears the pin on compare, 1:1 sets it.
// - The link select overrides channel 0's low mode bit.
// - Without toggle-on-wrap or full duty, clear or set compares hold the pin: zero duty for clear, full for set.
// - Full duty bit with toggle-on-wrap clear holds the pulse level.
// - The wrap flag sets when the counter returns to zero.
// - A channel flag sets on every compare of that channel.
// - Counter clear zeroes counter and prescaler, self-clears, reads zero.
// - Halt stops counting; reset leaves halt set.
module timer_compare_pwm_channels (
  input  wire logic                             pclk,            // APB clock, 40 MHz.
  input  wire logic                             presetn,         // Async reset, low.
  input  wire logic                             psel,            // APB select.
  input  wire logic                             penable,         // APB access phase.
  input  wire logic                             pwrite,          // APB write.
  input  wire logic [pwm_timer_pkg::ADDR_W-1:0] paddr,           // APB byte address.
  input  wire logic [pwm_timer_pkg::DATA_W-1:0] pwdata,          // APB write data.
  output logic      [pwm_timer_pkg::DATA_W-1:0] prdata,          // APB read data.
  output logic                                  pready,          // APB ready.
  output logic                                  pslverr,         // APB error.
  input  wire logic                             ext_tclk,        // External timer clock.
  output logic                                  channel0_pin_o,  // Channel 0 pin level.
  output logic                                  channel0_pin_oe, // Channel 0 drive.
  output logic                                  channel1_pin_o,  // Channel 1 pin level.
  output logic                                  channel1_pin_oe, // Channel 1 drive.
  output logic                                  irq_req          // Interrupt request.
);
  import pwm_timer_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // State.
  typedef struct packed {
    logic              wrap_flag;
    logic              wrap_ie;
    logic              halt;
    logic              clr;
    logic [2:0]        ps;
    logic [CNT_W-1:0]  limit;
    ch_cfg_t           ch0;
    ch_cfg_t           ch1;
    logic [CNT_W-1:0]  val0;
    logic [CNT_W-1:0]  val1;
    logic [2:0]        arm;    // Flag was read as one; a zero write may clear it.
    value_sel_t        sel;
    logic              last1;  // Channel 1 values written last.
    logic              pin0;
    logic              pin1;
    logic [DATA_W-1:0] rdata;
    logic              err;
  } top_state_t;

  top_state_t q;
  top_state_t d;

  timer_count_if tb ();

  logic             wr;
  logic             rd;
  logic             linked;
  logic             out0;
  logic             out1;
  logic [CNT_W-1:0] cval0;
  logic             cmp0;
  logic             cmp1;

  ////////////////////////////////////////////////////////////////////////////
  // Helpers.

  // Pin after a possible wrap toggle and compare action; full duty overrides when toggle-on-wrap is clear.
  function automatic logic next_pin(input logic p, input ch_cfg_t c,
                                    input logic wrap, input logic cmp);
    logic r;
    r = p;
    if (wrap && c.tov) begin
      r = ~r;
    end
    if (cmp) begin
      case (c.el)
        EL_TOGGLE: r = ~r;
        EL_CLEAR:  r = 1'b0;
        EL_SET:    r = 1'b1;
        default:   r = r;
      endcase
    end
    if (c.maxd && !c.tov) begin
      r = ~c.el[0];
    end
    return r;
  endfunction

  // Only word-aligned offsets of the seven registers answer without error.
  function automatic logic mapped(input logic [ADDR_W-1:0] a);
    logic m;
    m = 1'b0;
    if (a == OFS_TIMER_CS) begin
      m = 1'b1;
    end else if (a == OFS_COUNT || a == OFS_LIMIT) begin
      m = 1'b1;
    end else if (a == OFS_CH0_CS || a == OFS_CH0_VAL) begin
      m = 1'b1;
    end else if (a == OFS_CH1_CS || a == OFS_CH1_VAL) begin
      m = 1'b1;
    end
    return m;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Counter instance and its controls.
  timer_count_base #(.PRE_W(6)) u_base (
    .pclk    (pclk),
    .presetn (presetn),
    .tb      (tb.base)
  );

  assign tb.halt    = q.halt;
  assign tb.clr     = q.clr;
  assign tb.ps_code = q.ps;
  assign tb.limit   = q.limit;
  assign tb.ext_clk = ext_tclk;

  ////////////////////////////////////////////////////////////////////////////
  // Mode decode and compare detection.
  assign wr     = psel && penable && pwrite;
  assign rd     = psel && penable && !pwrite;
  assign linked = q.ch0.link;
  assign out0   = q.ch0.link || q.ch0.mode_lo;
  assign out1   = q.ch1.mode_lo && !linked;
  assign cval0  = (linked && q.sel == SEL_CH1) ? q.val1 : q.val0;
  assign cmp0   = tb.adv && out0 && (tb.count == cval0);
  assign cmp1   = tb.adv && out1 && (tb.count == q.val1);

  ////////////////////////////////////////////////////////////////////////////
  // Next state: bus access, buffering, pins and flags.
  always_comb begin
    d     = q;
    d.clr = 1'b0;
    // Read data is captured in the setup cycle so that prdata is a flop.
    if (psel && !penable) begin
      d.err   = !mapped(paddr);
      d.rdata = '0;
      if (paddr == OFS_TIMER_CS) begin
        d.rdata[7:0] = {q.wrap_flag, q.wrap_ie, q.halt, 2'b00, q.ps};
      end else if (paddr == OFS_COUNT) begin
        d.rdata[CNT_W-1:0] = tb.count;
      end else if (paddr == OFS_LIMIT) begin
        d.rdata[CNT_W-1:0] = q.limit;
      end else if (paddr == OFS_CH0_CS) begin
        d.rdata[7:0] = q.ch0;
      end else if (paddr == OFS_CH0_VAL) begin
        d.rdata[CNT_W-1:0] = q.val0;
      end else if (paddr == OFS_CH1_CS) begin
        d.rdata[7:0] = {q.ch1.flag, q.ch1.ie, 1'b0, q.ch1[4:0]};
      end else if (paddr == OFS_CH1_VAL) begin
        d.rdata[CNT_W-1:0] = q.val1;
      end
    end
    // A read that sees a flag set arms its clearing write.
    if (rd) begin
      if (paddr == OFS_TIMER_CS && q.wrap_flag) begin
        d.arm[0] = 1'b1;
      end else if (paddr == OFS_CH0_CS && q.ch0.flag) begin
        d.arm[1] = 1'b1;
      end else if (paddr == OFS_CH1_CS && q.ch1.flag) begin
        d.arm[2] = 1'b1;
      end
    end
    // Register writes. Writing one to a flag has no effect.
    if (wr) begin
      if (paddr == OFS_TIMER_CS) begin
        d.wrap_ie = pwdata[TCS_IE_BIT];
        d.halt    = pwdata[TCS_HALT_BIT];
        d.clr     = pwdata[TCS_CLR_BIT];
        d.ps      = pwdata[TCS_PS_LSB +: 3];
        if (q.arm[0] && !pwdata[TCS_FLAG_BIT]) begin
          d.wrap_flag = 1'b0;
        end
        d.arm[0] = 1'b0;
      end else if (paddr == OFS_LIMIT) begin
        d.limit = pwdata[CNT_W-1:0];
      end else if (paddr == OFS_CH0_CS) begin
        d.ch0[6:0] = pwdata[6:0];
        if (q.arm[1] && !pwdata[CH_FLAG_BIT]) begin
          d.ch0.flag = 1'b0;
        end
        d.arm[1] = 1'b0;
      end else if (paddr == OFS_CH0_VAL) begin
        d.val0 = pwdata[CNT_W-1:0];
        d.last1 = 1'b0;
      end else if (paddr == OFS_CH1_CS) begin
        // The high mode bit of channel 1 is reserved and stays zero.
        d.ch1.ie        = pwdata[6];
        d.ch1[4:0]      = pwdata[4:0];
        if (q.arm[2] && !pwdata[CH_FLAG_BIT]) begin
          d.ch1.flag = 1'b0;
        end
        d.arm[2] = 1'b0;
      end else if (paddr == OFS_CH1_VAL) begin
        d.val1  = pwdata[CNT_W-1:0];
        d.last1 = linked;
      end
    end
    // last written set at wrap
    // Follows the written link bit so an unlink drops the buffered set at once.
    if (!d.ch0.link) begin
      d.sel   = SEL_CH0;
      d.last1 = 1'b0;
    end else if (tb.wrap) begin
      d.sel = d.last1 ? SEL_CH1 : SEL_CH0;
    end
    if (out0) begin
      d.pin0 = next_pin(q.pin0, q.ch0, tb.wrap, cmp0);
    end
    if (out1) begin
      d.pin1 = next_pin(q.pin1, q.ch1, tb.wrap, cmp1);
    end
    // Hardware sets come last so an event beats a clear in the same cycle.
    // wrap flag set
    if (tb.wrap) begin
      d.wrap_flag = 1'b1;
    end
    // combined channel reports on channel 0
    if (cmp0) begin
      d.ch0.flag = 1'b1;
    end
    if (cmp1) begin
      d.ch1.flag = 1'b1;
    end
  end

  // State register; halt comes out of reset set.
  // reset leaves halt set
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q       <= '0;
      q.halt  <= TCS_HALT_RESET;
      q.limit <= LIMIT_RESET;
      q.ch0   <= CH_RESET;
      q.ch1   <= CH_RESET;
      q.val0  <= VALUE_RESET;
      q.val1  <= VALUE_RESET;
      q.sel   <= SEL_CH0;
    end else begin
      q <= d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs. The slave never inserts wait states.
  assign prdata          = q.rdata;
  assign pready          = 1'b1;
  assign pslverr         = psel && penable && q.err;
  assign channel0_pin_o  = q.pin0;
  assign channel0_pin_oe = out0 && (q.ch0.el != EL_OFF);
  assign channel1_pin_o  = q.pin1;
  assign channel1_pin_oe = out1 && (q.ch1.el != EL_OFF);
  assign irq_req         = (q.wrap_flag && q.wrap_ie) || (q.ch0.flag && q.ch0.ie)
                         || (q.ch1.flag && q.ch1.ie && !linked);

  ////////////////////////////////////////////////////////////////////////////
  // Checks.
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  chk_wrap_flag_set: assert property (tb.wrap |=> q.wrap_flag)
    else $error("wrap flag not set after wrap");

  chk_period_wrap: assert property (tb.wrap |-> tb.count == '0 &&
                                    $past(tb.count) == $past(q.limit))
    else $error("counter wrapped away from the limit");

  chk_halt_freeze: assert property (q.halt && !q.clr |=> $stable(tb.count))
    else $error("counter moved while halted");

  chk_clear_zero: assert property (q.clr |=> tb.count == '0 && !q.clr)
    else $error("clear did not zero the counter");

  chk_ch_flag_set: assert property (cmp0 |=> q.ch0.flag)
    else $error("channel flag missed a compare");

  chk_clear_on_cmp: assert property (cmp0 && q.ch0.el == EL_CLEAR &&
                                     !(q.ch0.maxd && !q.ch0.tov) |=> !q.pin0)
    else $error("clear-on-compare left pin high");

  chk_full_duty_hold: assert property (out0 && q.ch0.maxd && !q.ch0.tov &&
                                       q.ch0.el == EL_CLEAR |=> q.pin0 [*1])
    else $error("full duty did not hold pulse level");

  chk_zero_duty_hold: assert property (out0 && !q.ch0.tov && !q.ch0.maxd &&
                                       q.ch0.el == EL_CLEAR && !q.pin0 |=> !q.pin0)
    else $error("pin rose without toggle-on-wrap");

  chk_link_swap: assert property (linked && tb.wrap && q.last1 && !wr
                                  |=> q.sel == SEL_CH1)
    else $error("written set did not take over at wrap");

  chk_wrap_toggle: assert property (tb.wrap && out0 && q.ch0.tov && !cmp0 &&
                                    !q.ch0.maxd |=> q.pin0 != $past(q.pin0))
    else $error("pin did not toggle at wrap");

  chk_ch1_released: assert property (linked |-> !channel1_pin_oe && !cmp1)
    else $error("channel 1 active while linked");

  chk_linked_pin0: assert property (linked && q.ch0.el != EL_OFF |-> channel0_pin_oe)
    else $error("linked output missing on channel 0 pin");

  chk_unlinked_direct: assert property (!linked |-> cval0 == q.val0 &&
                                        q.sel == SEL_CH0)
    else $error("unlinked compare used a buffered value");

  cov_linked_swap: cover property (linked && tb.wrap ##1 q.sel == SEL_CH1);
  cov_pwm_period:  cover property (tb.wrap && out0 && q.ch0.tov ##[1:300] cmp0);
  cov_full_duty:   cover property (out0 && q.ch0.maxd && !q.ch0.tov);
  cov_flag_clear:  cover property (q.wrap_flag ##1 !q.wrap_flag);

endmodule

// *** pwm_timer_pkg.sv ***
// Shared constants and types of the two-channel compare and PWM timer.
// Assumes a 32-bit APB register bus with word-aligned byte addresses.
package pwm_timer_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Widths.
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int CNT_W  = 16;

  ////////////////////////////////////////////////////////////////////////////
  // Register byte offsets.
  localparam logic [ADDR_W-1:0] OFS_TIMER_CS = 8'h00; // timer_control_status
  localparam logic [ADDR_W-1:0] OFS_COUNT    = 8'h04; // live counter, read only
  localparam logic [ADDR_W-1:0] OFS_LIMIT    = 8'h08; // period_limit_pair
  localparam logic [ADDR_W-1:0] OFS_CH0_CS   = 8'h0C; // channel0_control_status
  localparam logic [ADDR_W-1:0] OFS_CH0_VAL  = 8'h10; // channel 0 channel_value_pair
  localparam logic [ADDR_W-1:0] OFS_CH1_CS   = 8'h14; // channel1_control_status
  localparam logic [ADDR_W-1:0] OFS_CH1_VAL  = 8'h18; // channel 1 channel_value_pair

  ////////////////////////////////////////////////////////////////////////////
  // Field positions of timer_control_status.
  localparam int TCS_FLAG_BIT = 7; // wrap_flag
  localparam int TCS_IE_BIT   = 6; // wrap_irq_enable
  localparam int TCS_HALT_BIT = 5; // counter_halt
  localparam int TCS_CLR_BIT  = 4; // counter clear, write only
  localparam int TCS_PS_LSB   = 0; // prescaler select, three bits
  // Field position of the channel event flag in a channel control register.
  localparam int CH_FLAG_BIT  = 7;

  ////////////////////////////////////////////////////////////////////////////
  // Reset values.
  localparam logic             TCS_HALT_RESET = 1'b1;
  localparam logic [CNT_W-1:0] LIMIT_RESET    = 16'hFFFF;
  localparam logic [CNT_W-1:0] VALUE_RESET    = 16'h0000;

  ////////////////////////////////////////////////////////////////////////////
  // Codes.
  localparam logic [2:0] PS_EXT    = 3'h7; // count rising edges of the external clock
  localparam logic [1:0] EL_OFF    = 2'h0;
  localparam logic [1:0] EL_TOGGLE = 2'h1;
  localparam logic [1:0] EL_CLEAR  = 2'h2;
  localparam logic [1:0] EL_SET    = 2'h3;

  // Channel control register, laid out bit for bit as software sees it.
  typedef struct packed {
    logic       flag;      // channel_event_flag
    logic       ie;        // channel_irq_enable
    logic       link;      // channel0_link_select (high mode bit)
    logic       mode_lo;   // low bit of channel_mode_pair
    logic [1:0] el;        // edge_level_pair
    logic       tov;       // toggle_on_wrap
    logic       maxd;      // full_duty_bit
  } ch_cfg_t;

  localparam ch_cfg_t CH_RESET = 8'h00;

  // Which value set drives the combined channel; one-hot.
  typedef enum logic [1:0] {
    SEL_CH0 = 2'b01,
    SEL_CH1 = 2'b10
  } value_sel_t;

endpackage

// *** timer_count_if.sv ***
// Link between the register block and the counter with its prescaler.
// Assumes both ends run on the same clock; all signals are synchronous.
`timescale 1ns/1ps
interface timer_count_if;
  import pwm_timer_pkg::*;
  logic             halt;     // Freeze counter and prescaler.
  logic             clr;      // One-cycle pulse zeroing counter and prescaler.
  logic [2:0]       ps_code;  // Prescaler select.
  logic [CNT_W-1:0] limit;    // Period limit.
  logic             ext_clk;  // External timer clock, already synchronous.
  logic [CNT_W-1:0] count;    // Registered counter value.
  logic             adv;      // Count changed at the last edge.
  logic             wrap;     // Count returned to zero at the last edge.

  modport ctrl (output halt, clr, ps_code, limit, ext_clk, input count, adv, wrap);
  modport base (input halt, clr, ps_code, limit, ext_clk, output count, adv, wrap);
endinterface

// *** timer_count_base.sv ***
// Prescaler and 16-bit modulo up-counter of the timer.
// Assumes ext_clk is synchronous to pclk; a rising edge there is one count.
`timescale 1ns/1ps
module timer_count_base #(
  parameter int PRE_W = 6 // Prescaler width; must reach divide by 64.
) (
  input wire logic            pclk,    // Bus clock.
  input wire logic            presetn, // Asynchronous reset, active low.
  timer_count_if.base         tb       // Control in, count out.
);
  import pwm_timer_pkg::*;

  if (PRE_W < 6) begin : g_bad_pre
    $error("timer_count_base: PRE_W must be at least 6");
  end

  typedef struct packed {
    logic [PRE_W-1:0] presc;
    logic [CNT_W-1:0] count;
    logic             ext_prev;
    logic             adv;
    logic             wrap;
  } base_state_t;

  base_state_t q;
  base_state_t d;

  // A prescaler output fires when all bits below the selected divide are ones.
  function automatic logic prescale_hit(input logic [PRE_W-1:0] p, input logic [2:0] code);
    logic [PRE_W-1:0] mask;
    mask = PRE_W'((1 << code) - 1);
    return (p & mask) == mask;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Next state. Clear beats halt, so clear with halt parks the count at zero.
  always_comb begin
    logic tick;
    tick       = 1'b0;
    d          = q;
    d.adv      = 1'b0;
    d.wrap     = 1'b0;
    d.ext_prev = tb.ext_clk;
    if (tb.clr) begin
      d.presc = '0;
      d.count = '0;
    end else if (!tb.halt) begin
      d.presc = q.presc + PRE_W'(1);
      if (tb.ps_code == PS_EXT) begin
        tick = tb.ext_clk && !q.ext_prev;
      end else begin
        tick = prescale_hit(q.presc, tb.ps_code);
      end
      if (tick) begin
        d.adv = 1'b1;
        if (q.count == tb.limit) begin
          d.count = '0;
          d.wrap  = 1'b1;
        end else begin
          d.count = q.count + CNT_W'(1);
        end
      end
    end
  end

  // State register.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign tb.count = q.count;
  assign tb.adv   = q.adv;
  assign tb.wrap  = q.wrap;

endmodule

// *** test_timer_compare_pwm_channels.sv ***
// Self-checking bench for the two-channel compare and PWM timer.
// Assumes one bus clock and an APB slave; every wait is bounded.
`timescale 1ns/1ps
module test_timer_compare_pwm_channels;
  import pwm_timer_pkg::*;

  logic              pclk, presetn, psel, penable, pwrite, ext_tclk;
  logic [ADDR_W-1:0] paddr;
  logic [DATA_W-1:0] pwdata, prdata, rd_q;
  logic              pready, pslverr, err_q, pin0, oe0, pin1, oe1, irq_req;
  logic [7:0]        cfg;
  int                n_mismatch, num_checks, lim, val, hi;

  timer_compare_pwm_channels i_dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .ext_tclk(ext_tclk), .channel0_pin_o(pin0),
    .channel0_pin_oe(oe0), .channel1_pin_o(pin1), .channel1_pin_oe(oe1),
    .irq_req(irq_req));

  //////////////////////////////////////////////////////////////////////////////
  // Bus clock; the external clock toggles so that its input never sits idle.
  always #12.5 pclk = ~pclk;
  always @(posedge pclk) ext_tclk <= ~ext_tclk;

  // Prints the counts and the verdict, then ends the run.
  task automatic finish_test();
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  // Compares one observed value with its expectation.
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("ERROR %s expected %0h seen %0h", what, exp, seen);
    end
  endtask

  // One APB transfer; starting on a fresh edge keeps release and setup apart.
  task automatic apb(input logic wr, input logic [ADDR_W-1:0] a, input logic [31:0] d);
    int i;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    for (i = 0; i < 16; i++) begin
      @(posedge pclk);
      if (pready === 1'b1) break;
    end
    if (i == 16) begin
      n_mismatch++;
      finish_test();
    end
    rd_q = prdata;
    err_q = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // Halt, clear, period, width, channel setup, then release at prescale 0.
  task automatic setup(input logic [7:0] c, input int l, input int v);
    apb(1'b1, OFS_TIMER_CS, 32'h20);
    apb(1'b1, OFS_TIMER_CS, 32'h30);
    apb(1'b1, OFS_LIMIT, l);
    apb(1'b1, OFS_CH0_VAL, v);
    apb(1'b1, OFS_CH0_CS, {24'h0, c});
    apb(1'b1, OFS_TIMER_CS, 32'h00);
  endtask

  // Counts the cycles in which the chosen channel pin is high.
  task automatic measure(input logic ch, input int n, output int h);
    h = 0;
    repeat (n) begin
      @(negedge pclk);
      if ((ch ? pin1 : pin0) === 1'b1) h++;
    end
  endtask

  // High cycles per period from level action, wrap toggle and full duty.
  function automatic int exp_hi(logic [7:0] c, int l, int v);
    int p;
    p = l + 1;
    if (c[1]) return c[2] ? p - v : v;
    if (c[0]) return c[2] ? 0 : p;
    return c[2] ? p : 0;
  endfunction

  //////////////////////////////////////////////////////////////////////////////
  // Main sequence.
  initial begin
    pclk = 1'b0;
    presetn = 1'b0;
    {psel, penable, pwrite, ext_tclk} = 4'h0;
    paddr = 8'h00;
    pwdata = 32'h0;
    n_mismatch = 0;
    num_checks = 0;
    void'($urandom(32'h1B7C8C69));
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, OFS_TIMER_CS, 32'h0);
    chk("timer_cs reset", rd_q, 32'h20);
    apb(1'b0, OFS_LIMIT, 32'h0);
    chk("limit reset", rd_q, 32'hFFFF);
    apb(1'b0, 8'h1C, 32'h0);
    chk("unmapped error", err_q, 32'h1);
    apb(1'b1, OFS_TIMER_CS, 32'h00);
    apb(1'b0, OFS_COUNT, 32'h0);
    val = rd_q;
    apb(1'b0, OFS_COUNT, 32'h0);
    chk("count step", rd_q - val, 32'h3);
    apb(1'b1, OFS_TIMER_CS, 32'h30);
    apb(1'b0, OFS_COUNT, 32'h0);
    val = rd_q;
    apb(1'b0, OFS_COUNT, 32'h0);
    chk("count cleared", rd_q, 32'h0);
    chk("count halted", rd_q, val);
    // divide by four and external edges over a 64-cycle window.
    for (int k = 2; k < 8; k += 5) begin
      apb(1'b1, OFS_TIMER_CS, k);
      apb(1'b0, OFS_COUNT, 32'h0);
      val = rd_q;
      repeat (61) @(posedge pclk);
      apb(1'b0, OFS_COUNT, 32'h0);
      chk("count rate", rd_q - val, (k == 2) ? 32'd16 : 32'd32);
    end
    // clear and set levels with every wrap and full duty mix.
    for (int k = 0; k < 8; k++) begin
      cfg = {4'h1, 1'b1, k[2], k[1], k[0]};
      lim = (k == 2) ? 255 : 2 + $urandom_range(14);
      val = (k == 2) ? 128 : (k == 3) ? lim : (k == 6) ? 0 : $urandom_range(lim);
      setup(cfg, lim, val);
      repeat (3 * (lim + 1)) @(posedge pclk);
      measure(1'b0, 4 * (lim + 1), hi);
      chk("pwm high", hi, 4 * exp_hi(cfg, lim, val));
      chk("ch0 drive", oe0, 32'h1);
    end
    // unbuffered rewrite takes effect at once.
    // shrink after the compare, grow after the wrap.
    hi = (lim - 1 < val) || (val == 0);
    for (int i = 0; i < 600 && pin0 !== hi[0]; i++) @(negedge pclk);
    chk("sync level", pin0, hi);
    apb(1'b1, OFS_CH0_VAL, lim - 1);
    repeat (2 * (lim + 1)) @(posedge pclk);
    measure(1'b0, lim + 1, hi);
    chk("rewrite high", hi, exp_hi(cfg, lim, lim - 1));
    // channel 1 on its own pin while unlinked.
    apb(1'b1, OFS_CH1_VAL, 32'h1);
    apb(1'b1, OFS_CH1_CS, 32'h1A);
    repeat (3 * (lim + 1)) @(posedge pclk);
    measure(1'b1, 4 * (lim + 1), hi);
    chk("ch1 pwm high", hi, 4 * exp_hi(8'h1A, lim, 1));
    chk("ch1 drive", oe1, 32'h1);
    // linked pair on the channel 0 pin.
    setup(8'h3A, 11, 3);
    apb(1'b1, OFS_CH1_CS, 32'h1A);
    repeat (24) @(posedge pclk);
    measure(1'b0, 48, hi);
    chk("linked ch0 set", hi, 32'd12);
    apb(1'b1, OFS_CH1_VAL, 32'h7);
    repeat (24) @(posedge pclk);
    measure(1'b0, 48, hi);
    chk("linked ch1 set", hi, 32'd28);
    chk("ch1 released", oe1, 32'h0);
    // flags, interrupt level and two-step clear.
    apb(1'b1, OFS_TIMER_CS, 32'h60);
    apb(1'b0, OFS_TIMER_CS, 32'h0);
    chk("wrap flag set", rd_q, 32'hE0);
    chk("irq raised", irq_req, 32'h1);
    apb(1'b1, OFS_TIMER_CS, 32'h60);
    apb(1'b0, OFS_TIMER_CS, 32'h0);
    chk("wrap flag clear", rd_q, 32'h60);
    chk("irq dropped", irq_req, 32'h0);
    apb(1'b0, OFS_CH0_CS, 32'h0);
    chk("ch0 flag", rd_q[7], 32'h1);
    finish_test();
  end
endmodule
